/* ifc_fault_check.v */
// Instruction fault check unit with Wishbone register access
//
// Chosen here: the register addresses and the Wishbone register port.
`include "ifc_map.vh"
module ifc_fault_check (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [31:0] i_wb_adr,
  input wire [31:0] i_wb_dat,
  input wire [3:0] i_wb_sel,
  input wire i_wb_we,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_chk_valid,
  input wire [7:0] i_opcode,
  input wire i_protected_only,
  input wire i_system_setup,
  input wire i_word_access,
  input wire [15:0] i_offset,
  input wire [15:0] i_seg_limit,
  input wire i_mem_op,
  input wire i_limit_viol,
  input wire i_rights_viol,
  input wire i_stack_seg,
  input wire i_seg_load,
  input wire i_load_to_ss,
  input wire i_seg_present,
  input wire [1:0] i_requested_privilege_level,
  input wire [1:0] i_descriptor_privilege_level,
  input wire i_far_transfer,
  input wire i_ctl_transfer,
  input wire i_target_in_code_limit,
  input wire i_priv_only,
  input wire i_io_sensitive,
  input wire i_flag_load,
  input wire [15:0] i_flag_src,
  input wire i_sel_check,
  input wire i_esc,
  input wire i_esc_xfer,
  input wire i_auto_lock,
  input wire i_lock_prefix,
  input wire i_multi_xfer_gap,
  input wire i_desc_read,
  input wire i_three_part_ea,
  input wire [3:0] i_base_clocks,
  input wire [7:0] i_imm_lo,
  input wire [15:0] i_imm_full,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  output reg o_fault,
  output reg [7:0] o_vector,
  output reg o_commit,
  output reg o_bus_exclusive,
  output reg o_reg_is_dest,
  output reg o_word_op,
  output reg [15:0] o_imm_value,
  output reg [3:0] o_exec_clocks,
  output reg [15:0] o_flags,
  output reg o_write_result
);
  reg rst_meta_ff;
  reg rst_sync_ff;
  reg protected_mode_ff;
  reg [1:0] current_privilege_level_ff;
  reg [7:0] last_vector_ff;
  reg [7:0] fault_count_ff;
  reg [31:0] nxt_wb_dat;
  wire rst_n;
  wire wb_req;
  wire [1:0] io_privilege_level;
  wire cpl_gt_io_privilege_level;
  wire word_wrap;
  wire seg_priv_bad;
  reg fault;
  reg [7:0] vector;
  reg [15:0] nxt_flags;
  reg nxt_fault;
  reg [7:0] nxt_vector;
  reg nxt_commit;
  reg nxt_bus_exclusive;
  reg nxt_reg_is_dest;
  reg nxt_word_op;
  reg [15:0] nxt_imm_value;
  reg [3:0] nxt_exec_clocks;
  reg nxt_write_result;
  wire fault_taken;
  wire sel_priv_miss;
  wire flag_write;
  wire lock_request;
  wire ctrl_wr;

  function [1:0] max_pl;
    input [1:0] a;
    input [1:0] b;
    begin
      max_pl = (a > b) ? a : b;
    end
  endfunction

  function [15:0] sign_ext8;
    input [7:0] b;
    begin
      sign_ext8 = {{8{b[7]}}, b};
    end
  endfunction

  // Reset release
  always @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign io_privilege_level = o_flags[`IFC_FLAG_IO_PRIVILEGE_LEVEL_HI:`IFC_FLAG_IO_PRIVILEGE_LEVEL_LO];
  assign cpl_gt_io_privilege_level = current_privilege_level_ff > io_privilege_level;
  assign word_wrap = i_word_access & (i_offset == `IFC_OFS_LAST);
  assign seg_priv_bad = max_pl(current_privilege_level_ff, i_requested_privilege_level)
    > i_descriptor_privilege_level;
  assign fault_taken = i_chk_valid & fault;
  assign sel_priv_miss = i_sel_check & protected_mode_ff & seg_priv_bad;
  assign flag_write = i_chk_valid & ~fault & i_flag_load;
  assign lock_request = i_auto_lock | i_lock_prefix | i_desc_read;
  assign ctrl_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0]
    & (i_wb_adr == `IFC_ADDR_CTRL);

  // Fault priority and vector selection
  always @*
  begin
    fault = 1'b0;
    vector = 8'h00;
    if (!protected_mode_ff)
    begin
      if (i_protected_only && !i_system_setup)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_UNDEF_OP;
      end
      else if (i_esc && i_esc_xfer && (i_offset > i_seg_limit))
      begin
        fault = 1'b1;
        vector = `IFC_VEC_CPSO;
      end
      else if (i_mem_op && word_wrap)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
    end
    else
    begin
      if (i_priv_only && current_privilege_level_ff != 2'b00)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
      else if (i_io_sensitive && cpl_gt_io_privilege_level)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
      else if (i_seg_load && !i_sel_check && seg_priv_bad)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
      else if (i_seg_load && !i_sel_check && !i_seg_present)
      begin
        fault = 1'b1;
        vector = i_load_to_ss ? `IFC_VEC_STACK : `IFC_VEC_NOT_PRESENT;
      end
      else if (i_far_transfer && seg_priv_bad)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
      else if (i_ctl_transfer && !i_target_in_code_limit)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
      else if (i_esc && i_esc_xfer && i_limit_viol)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_CPSO;
      end
      else if ((i_mem_op || i_esc) && i_limit_viol && i_stack_seg)
      begin
        fault = 1'b1;
        vector = `IFC_VEC_STACK;
      end
      else if ((i_mem_op || i_esc) && (i_limit_viol || i_rights_viol))
      begin
        fault = 1'b1;
        vector = `IFC_VEC_GP;
      end
    end
  end

  // Flag image update
  always @*
  begin
    nxt_flags = i_flag_src;
    if (protected_mode_ff)
    begin
      if (cpl_gt_io_privilege_level)
        nxt_flags[`IFC_FLAG_IF_BIT] = o_flags[`IFC_FLAG_IF_BIT];
      if (current_privilege_level_ff != 2'b00)
        nxt_flags[`IFC_FLAG_IO_PRIVILEGE_LEVEL_HI:`IFC_FLAG_IO_PRIVILEGE_LEVEL_LO] = io_privilege_level;
    end
    else
    begin
      nxt_flags[`IFC_FLAG_IO_PRIVILEGE_LEVEL_HI:`IFC_FLAG_IO_PRIVILEGE_LEVEL_LO] = 2'b00;
      nxt_flags[`IFC_FLAG_NT_BIT] = 1'b0;
    end
  end

  // Next values of the check outputs
  always @*
  begin
    nxt_fault = fault_taken;
    nxt_vector = fault_taken ? vector : 8'h00;
    nxt_commit = i_chk_valid & ~fault;
    nxt_bus_exclusive = lock_request
      & ~(i_multi_xfer_gap & ~i_desc_read);
    nxt_reg_is_dest = i_opcode[`IFC_OP_DIR_BIT];
    nxt_word_op = i_opcode[`IFC_OP_WIDTH_BIT];
    nxt_imm_value = i_opcode[`IFC_OP_SEXT_BIT] ? sign_ext8(i_imm_lo) : i_imm_full;
    nxt_exec_clocks = i_base_clocks;
    if (i_three_part_ea)
      nxt_exec_clocks = i_base_clocks + `IFC_BASE_EXTRA_CLK;
    nxt_write_result = i_chk_valid & ~fault & ~sel_priv_miss;
  end

  // Check result stage
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_fault <= 1'b0;
      o_vector <= 8'h00;
      o_commit <= 1'b0;
      o_write_result <= 1'b0;
    end
    else
    begin
      o_fault <= nxt_fault;
      o_vector <= nxt_vector;
      o_commit <= nxt_commit;
      o_write_result <= nxt_write_result;
    end
  end

  // Decode field stage
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_reg_is_dest <= 1'b0;
      o_word_op <= 1'b0;
      o_imm_value <= 16'h0000;
      o_exec_clocks <= 4'h0;
    end
    else
    begin
      o_reg_is_dest <= nxt_reg_is_dest;
      o_word_op <= nxt_word_op;
      o_imm_value <= nxt_imm_value;
      o_exec_clocks <= nxt_exec_clocks;
    end
  end

  // Bus-exclusive output
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_bus_exclusive <= 1'b0;
    else
      o_bus_exclusive <= nxt_bus_exclusive;
  end

  // Flag image and fault record
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_flags <= `IFC_FLAG_RST;
      last_vector_ff <= 8'h00;
      fault_count_ff <= 8'h00;
    end
    else
    begin
      if (i_chk_valid && !fault && sel_priv_miss)
        o_flags[`IFC_FLAG_ZF_BIT] <= 1'b0;
      else if (flag_write)
        o_flags <= nxt_flags;
      if (fault_taken)
      begin
        last_vector_ff <= vector;
        fault_count_ff <= fault_count_ff + 8'h01;
      end
    end
  end

  // Wishbone read mux
  always @*
  begin
    nxt_wb_dat = 32'h0000_0000;
    case (i_wb_adr)
      `IFC_ADDR_CTRL: nxt_wb_dat = {29'h0, current_privilege_level_ff, protected_mode_ff};
      `IFC_ADDR_STATUS: nxt_wb_dat = {16'h0, fault_count_ff, last_vector_ff};
      `IFC_ADDR_FLAGS: nxt_wb_dat = {16'h0, o_flags};
      `IFC_ADDR_DECODE: nxt_wb_dat = {27'h0, o_exec_clocks, o_word_op};
      default: nxt_wb_dat = 32'h0000_0000;
    endcase
  end

  // Wishbone slave, one wait state, unmapped reads zero
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `IFC_CTRL_RST;
    end
    else
    begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? nxt_wb_dat : 32'h0000_0000;
    end
  end

  // Mode and privilege register, written at the acknowledge edge
  always @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      protected_mode_ff <= 1'b0;
      current_privilege_level_ff <= 2'b00;
    end
    else if (ctrl_wr)
    begin
      protected_mode_ff <= i_wb_dat[`IFC_CTRL_PM_BIT];
      current_privilege_level_ff <= i_wb_dat[`IFC_CTRL_CPL_HI:`IFC_CTRL_CPL_LO];
    end
  end
endmodule

/* ifc_fault_check_properties.sv */
// Checker with the concurrent properties of the fault check unit
module ifc_fault_check_props (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_chk_valid,
  input wire i_three_part_ea,
  input wire i_auto_lock,
  input wire i_multi_xfer_gap,
  input wire i_desc_read,
  input wire [7:0] i_opcode,
  input wire [7:0] i_imm_lo,
  input wire [7:0] o_vector,
  input wire [3:0] i_base_clocks,
  input wire [3:0] o_exec_clocks,
  input wire [15:0] o_imm_value,
  input wire o_fault,
  input wire o_commit,
  input wire o_bus_exclusive,
  input wire o_reg_is_dest
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  chk_dir_dest: assert property (i_chk_valid && i_opcode[1] |=> o_reg_is_dest)
    else $error("direction bit ignored");
  chk_imm_sext: assert property (i_chk_valid && i_opcode[1] |=>
    o_imm_value == 16'($signed($past(i_imm_lo)))) else $error("byte not extended");
  chk_ea_extra: assert property (i_chk_valid |=>
    o_exec_clocks == $past(i_base_clocks) + {3'h0, $past(i_three_part_ea)})
    else $error("clock count wrong");
  chk_auto_lock: assert property (i_chk_valid && i_auto_lock && !i_multi_xfer_gap
    |=> o_bus_exclusive) else $error("exclusive not driven");
  chk_desc_lock: assert property (i_chk_valid && i_desc_read |=> o_bus_exclusive)
    else $error("descriptor read not exclusive");
  chk_fault_once: assert property (i_chk_valid |=> o_fault != o_commit)
    else $error("fault and commit clash");
  chk_idle_quiet: assert property (!i_chk_valid |=> !o_fault && !o_commit)
    else $error("result without instruction");
  chk_fault_vec: assert property (o_fault |->
    o_vector inside {8'h06, 8'h09, 8'h0B, 8'h0C, 8'h0D}) else $error("bad vector");
  cover property (o_fault && o_vector == 8'h09);
  cover property (o_bus_exclusive);
  cover property (i_chk_valid && i_three_part_ea);
endmodule
bind ifc_fault_check ifc_fault_check_props u_props (.*);

/* ifc_map.vh */
// Constants for the instruction fault check unit
`ifndef IFC_MAP_VH
`define IFC_MAP_VH
`define IFC_VEC_UNDEF_OP 8'h06
`define IFC_VEC_CPSO 8'h09
`define IFC_VEC_NOT_PRESENT 8'h0B
`define IFC_VEC_STACK 8'h0C
`define IFC_VEC_GP 8'h0D
`define IFC_OFS_LAST 16'hFFFF
`define IFC_FLAG_ZF_BIT 6
`define IFC_FLAG_IF_BIT 9
`define IFC_FLAG_IO_PRIVILEGE_LEVEL_LO 12
`define IFC_FLAG_IO_PRIVILEGE_LEVEL_HI 13
`define IFC_FLAG_NT_BIT 14
`define IFC_FLAG_RST 16'h0002
`define IFC_BASE_EXTRA_CLK 4'h1
`define IFC_OP_WIDTH_BIT 0
`define IFC_OP_DIR_BIT 1
`define IFC_OP_SEXT_BIT 1
`define IFC_CTRL_PM_BIT 0
`define IFC_CTRL_CPL_LO 1
`define IFC_CTRL_CPL_HI 2
`define IFC_ADDR_CTRL 32'h0000_0000
`define IFC_ADDR_STATUS 32'h0000_0004
`define IFC_ADDR_FLAGS 32'h0000_0008
`define IFC_ADDR_DECODE 32'h0000_000C
`define IFC_CTRL_RST 32'h0000_0000
`endif

/* tb_instruction_fault_checks.sv */
// Self-checking bench for the instruction fault check unit
`include "ifc_map.vh"
module tb_instruction_fault_checks;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_rst_b, i_wb_we, i_wb_cyc, i_wb_stb, i_chk_valid, i_protected_only;
  logic i_system_setup, i_word_access, i_mem_op, i_limit_viol, i_rights_viol, i_stack_seg;
  logic i_seg_load, i_load_to_ss, i_seg_present, i_far_transfer, i_ctl_transfer, i_esc;
  logic i_target_in_code_limit, i_priv_only, i_io_sensitive, i_flag_load, i_sel_check;
  logic i_esc_xfer, i_auto_lock, i_lock_prefix, i_multi_xfer_gap, i_desc_read, i_three_part_ea;
  logic o_wb_ack, o_fault, o_commit, o_bus_exclusive, o_reg_is_dest, o_word_op, o_write_result;
  logic [31:0] i_wb_adr, i_wb_dat, o_wb_dat, rd;
  logic [15:0] i_offset, i_seg_limit, i_flag_src, i_imm_full, o_imm_value, o_flags;
  logic [7:0] i_opcode, i_imm_lo, o_vector;
  logic [3:0] i_wb_sel, i_base_clocks, o_exec_clocks;
  logic [1:0] i_requested_privilege_level, i_descriptor_privilege_level;
  int bad_count = 0;
  int tests_run = 0;
  int faults = 0;
  logic dpl_zero = 1'b0;
  ifc_fault_check uut (.*);
  initial
  begin
    i_core_clk = 0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  function automatic logic [15:0] exp_imm(logic [7:0] op, logic [7:0] lo, logic [15:0] full);
    return op[1] ? {{8{lo[7]}}, lo} : full;
  endfunction
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    @(posedge i_core_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, we, adr, dat};
    @(posedge i_core_clk);
    while (o_wb_ack !== 1'b1)
      @(posedge i_core_clk);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
    @(posedge i_core_clk);
  endtask
  // Bit n of m raises one check input; bits 2, 8, 12, 14 and 15 also drive a second input
  task automatic apply(input logic [15:0] m, input logic v);
    i_chk_valid <= v;
    {i_auto_lock, i_sel_check, i_flag_load, i_ctl_transfer, i_io_sensitive, i_priv_only,
      i_load_to_ss, i_seg_load, i_mem_op, i_stack_seg, i_limit_viol, i_esc_xfer, i_esc,
      i_word_access, i_system_setup, i_protected_only} <= m;
    i_desc_read <= m[15];
    i_seg_present <= !m[8];
    i_target_in_code_limit <= !m[12];
    i_offset <= m[2] ? `IFC_OFS_LAST : 16'($urandom_range(16'hFFFE, 16'h0001));
    i_requested_privilege_level <= 2'h3;
    i_descriptor_privilege_level <= (m[14] || dpl_zero) ? 2'h0 : 2'h3;
  endtask
  task automatic chk(input logic [15:0] m, input logic [7:0] v);
    @(posedge i_core_clk);
    apply(m, 1'b1);
    @(posedge i_core_clk);
    apply(16'h0000, 1'b0);
    #1;
    faults += (v != 8'h00);
    cmp({o_fault, o_commit, o_vector}, {v != 8'h00, v == 8'h00, v});
  endtask
  initial
  begin
    {i_rst_b, i_wb_we, i_wb_cyc, i_wb_stb, i_wb_adr, i_wb_dat, i_opcode, i_imm_lo} = '0;
    {i_imm_full, i_base_clocks, i_three_part_ea, i_lock_prefix, i_multi_xfer_gap} = '0;
    {i_flag_src, i_seg_limit, i_rights_viol, i_far_transfer} = '0;
    i_wb_sel = 4'hF;
    void'($urandom(32'h31AB4207));
    apply(16'h0000, 1'b0);
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    #1;
    cmp(o_flags, `IFC_FLAG_RST);
    wb(1'b0, `IFC_ADDR_CTRL, 32'h0);
    cmp(rd, `IFC_CTRL_RST);
    wb(1'b0, 32'h0000_0010, 32'h0);
    cmp(rd, 32'h0);
    repeat (24)
    begin
      {i_opcode, i_imm_lo, i_imm_full, i_three_part_ea, i_lock_prefix} <= {$urandom, 2'($urandom)};
      i_multi_xfer_gap <= 1'($urandom);
      i_base_clocks <= 4'($urandom_range(14));
      chk(16'h0000, 8'h00);
      cmp({o_reg_is_dest, o_word_op}, i_opcode[1:0]);
      cmp(o_imm_value, exp_imm(i_opcode, i_imm_lo, i_imm_full));
      cmp(o_exec_clocks, i_base_clocks + 4'(i_three_part_ea));
      if (!i_multi_xfer_gap)
        cmp(o_bus_exclusive, i_lock_prefix);
    end
    wb(1'b0, `IFC_ADDR_DECODE, 32'h0);
    cmp(rd[4:0], {i_base_clocks + 4'(i_three_part_ea), i_opcode[0]});
    chk(16'h0001, `IFC_VEC_UNDEF_OP);
    chk(16'h0003, 8'h00);
    chk(16'h0084, `IFC_VEC_GP);
    chk(16'h0038, `IFC_VEC_CPSO);
    i_flag_src <= 16'hFFFF;
    chk(16'h2000, 8'h00);
    cmp(o_flags[14:12], 3'h0);
    wb(1'b1, `IFC_ADDR_CTRL, 32'h1);
    i_flag_src <= 16'h2240;
    chk(16'h2000, 8'h00);
    cmp({o_flags[13:12], o_flags[9]}, 3'h5);
    wb(1'b1, `IFC_ADDR_CTRL, 32'h7);
    i_flag_src <= 16'h0040;
    chk(16'h2000, 8'h00);
    cmp({o_flags[13:12], o_flags[9], o_flags[6]}, 4'hB);
    chk(16'h0800, `IFC_VEC_GP);
    chk(16'h0400, `IFC_VEC_GP);
    chk(16'h00A0, `IFC_VEC_GP);
    chk(16'h00E0, `IFC_VEC_STACK);
    chk(16'h0100, `IFC_VEC_NOT_PRESENT);
    chk(16'h0300, `IFC_VEC_STACK);
    dpl_zero <= 1'b1;
    chk(16'h0100, `IFC_VEC_GP);
    i_far_transfer <= 1'b1;
    chk(16'h0000, `IFC_VEC_GP);
    {dpl_zero, i_far_transfer} <= 2'h0;
    chk(16'h1000, `IFC_VEC_GP);
    chk(16'h0028, `IFC_VEC_GP);
    chk(16'h0068, `IFC_VEC_STACK);
    chk(16'h0038, `IFC_VEC_CPSO);
    chk(16'h4000, 8'h00);
    cmp({o_write_result, o_flags[6]}, 2'h0);
    chk(16'h8000, 8'h00);
    cmp(o_bus_exclusive, 1'b1);
    wb(1'b1, `IFC_ADDR_CTRL, 32'h5);
    chk(16'h0800, 8'h00);
    wb(1'b0, `IFC_ADDR_STATUS, 32'h0);
    cmp(rd[15:0], {faults[7:0], `IFC_VEC_CPSO});
    complete_run();
  end
  initial
  begin
    #20us;
    bad_count++;
    complete_run();
  end
endmodule
